// ===== core/cbss_pkg.sv
// constants for the processor bus-select and shift-gating datapath
// assumes a single 100 MHz clock and an ahb-lite master for software access
// Overview of operation
// - mem data or index set strobe loads the current c-bus value into that register
// - shift-left and multiply feed bit 0 into shift-left gates via first gate; the code raises the first gate but routes no bit through it
// - shift-right and multiply feed bit 14 into shift-right gates via second gate
// - shift-right and multiply feed bit 15 into shift-right gates via third gate
// - shift-left and divide feed bit 15 into shift-left gates via fourth gate
// - left shift enable opens left gates during shift-left or divide
// - right shift enable opens all right gates during shift-right or multiply
// - adder select routes adder sum onto the c bus
// - g-bus select steers g bus into the adder as an operand
// - two g-bus gates: operand register inverted and unmodified
// - instruction register gated onto g bus in groups 0-8, 9-10, 11-15
// - separate selects gate a, b, p or x onto the s bus
// - pc selected for normal update enables the incrementer to advance pc
// - shifting allowed only during shift, multiply or divide; control sequences it; the code also raises shift_operation_enable for op codes 5-7
// - instruction register holds the instruction through the execute cycle
// - long-shift control on selects a register, off selects b register
package cbss_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OP     = 8'h04;
  localparam logic [7:0] ADDR_STROBE = 8'h08;
  localparam logic [7:0] ADDR_ACC    = 8'h0C;
  localparam logic [7:0] ADDR_EXT    = 8'h10;
  localparam logic [7:0] ADDR_PC     = 8'h14;
  localparam logic [7:0] ADDR_INDEX  = 8'h18;
  localparam logic [7:0] ADDR_MDR    = 8'h1C;
  localparam logic [7:0] ADDR_INSTR  = 8'h20;
  localparam logic [7:0] ADDR_OPND   = 8'h24;
  localparam logic [7:0] ADDR_BUSES  = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  // control register field positions
  localparam int unsigned CTL_ACC_S   = 0;
  localparam int unsigned CTL_EXT_S   = 1;
  localparam int unsigned CTL_PC_S    = 2;
  localparam int unsigned CTL_IDX_S   = 3;
  localparam int unsigned CTL_OPND    = 4;
  localparam int unsigned CTL_OPNDI   = 5;
  localparam int unsigned CTL_ULO     = 6;
  localparam int unsigned CTL_UMID    = 7;
  localparam int unsigned CTL_UHI     = 8;
  localparam int unsigned CTL_GADD    = 9;
  localparam int unsigned CTL_ADDC    = 10;
  localparam int unsigned CTL_PCINC   = 11;
  localparam int unsigned CTL_LONG    = 12;
  localparam int unsigned CTL_W       = 13;
  // op register: shift operation kind
  localparam int unsigned OP_W        = 3;
  localparam logic [OP_W-1:0] OP_NONE = 3'h0;
  localparam logic [OP_W-1:0] OP_SHL  = 3'h1;
  localparam logic [OP_W-1:0] OP_SHR  = 3'h2;
  localparam logic [OP_W-1:0] OP_MUL  = 3'h3;
  localparam logic [OP_W-1:0] OP_DIV  = 3'h4;
  // strobe register bits, write-one pulses
  localparam int unsigned STB_MDR     = 0;
  localparam int unsigned STB_IDX     = 1;
  localparam int unsigned STB_ACC     = 2;
  localparam int unsigned STB_EXT     = 3;
  localparam int unsigned STB_PC      = 4;
  localparam int unsigned STB_INSTR   = 5;
  localparam int unsigned STB_OPND    = 6;
  localparam int unsigned STB_MDEXT   = 7;
  localparam int unsigned STB_STEP    = 8;
  localparam int unsigned STB_W       = 9;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
endpackage

// ===== core/cbss_shift_gates.sv
// shift-edge gating: routes edge bits into left and right shift gates
// assumes the operation code is held stable by the sequencer while shifting
`timescale 1ns/10ps
module cbss_shift_gates #(
  parameter int unsigned W = 16
) (
  input  wire logic [2:0]   op,
  input  wire logic         active,
  input  wire logic [W-1:0] word,
  output logic              gate_first,
  output logic              gate_second,
  output logic              gate_third,
  output logic              gate_fourth,
  output logic              left_en,
  output logic              right_en,
  output logic [W-1:0]      shifted
);
  logic is_shl, is_shr, is_mul, is_div;
  always_comb begin
    is_shl      = active && (op == cbss_pkg::OP_SHL);
    is_shr      = active && (op == cbss_pkg::OP_SHR);
    is_mul      = active && (op == cbss_pkg::OP_MUL);
    is_div      = active && (op == cbss_pkg::OP_DIV);
    gate_first  = is_shl || is_mul;
    gate_second = is_shr || is_mul;
    gate_third  = is_shr || is_mul;
    gate_fourth = is_shl || is_div;
    left_en     = is_shl || is_div;
    // right enable is masked by left enable, so the two enables stay exclusive
    right_en    = (is_shr || is_mul) && !left_en;
    shifted     = word;
    if (left_en) begin
      // bit 15 wraps to bit 0 through the fourth gate
      shifted = {word[W-2:0], gate_fourth ? word[W-1] : 1'b0};
    end else if (right_en) begin
      // sign is kept by the third gate; the second gate passes bit 14 down to bit 13
      shifted = {gate_third ? word[W-1] : 1'b0, word[W-1], gate_second ? word[W-2] : 1'b0,
                 word[W-3:1]};
    end
  end
endmodule

// ===== core/cbss_datapath.sv
// bus-select and shift-gating datapath, registers reached over ahb-lite
// assumes a single ahb-lite master, single word transfers, response always okay
`timescale 1ns/10ps
module cbss_datapath #(
  parameter int unsigned W = cbss_pkg::DATA_W
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             left_shift_enable,
  output logic             right_shift_enable,
  output logic             shift_operation_enable,
  output logic [W-1:0]     cbus
);
  logic [cbss_pkg::CTL_W-1:0] ctrl;
  logic [cbss_pkg::OP_W-1:0]  op;
  logic [W-1:0] acc, ext, pc, index_reg, mdr, instr, opnd;
  logic [cbss_pkg::STB_W-1:0] strobe;
  logic         ap_valid, ap_write;
  logic [7:0]   ap_addr;
  logic [31:0]  rd_word;
  logic [W-1:0] sbus, gbus, sum, next_cbus, target, shifted;
  logic         g_first, g_second, g_third, g_fourth, l_en, r_en, shifting;

  // address phase capture; the slave never stalls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // control, op and strobe writes; strobes last one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= '0;
      op     <= cbss_pkg::OP_NONE;
      strobe <= '0;
    end else begin
      strobe <= '0;
      if (ap_valid && ap_write) begin
        case (ap_addr)
          cbss_pkg::ADDR_CTRL:   ctrl   <= hwdata[cbss_pkg::CTL_W-1:0];
          cbss_pkg::ADDR_OP:     op     <= hwdata[cbss_pkg::OP_W-1:0];
          cbss_pkg::ADDR_STROBE: strobe <= hwdata[cbss_pkg::STB_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // s bus: or of the selected registers
  always_comb begin
    sbus = '0;
    if (ctrl[cbss_pkg::CTL_ACC_S]) sbus = sbus | acc;
    if (ctrl[cbss_pkg::CTL_EXT_S]) sbus = sbus | ext;
    if (ctrl[cbss_pkg::CTL_PC_S])  sbus = sbus | pc;
    if (ctrl[cbss_pkg::CTL_IDX_S]) sbus = sbus | index_reg;
  end

  always_comb begin
    gbus = '0;
    if (ctrl[cbss_pkg::CTL_OPND])  gbus = gbus | opnd;
    if (ctrl[cbss_pkg::CTL_OPNDI]) gbus = gbus | ~opnd;
    if (ctrl[cbss_pkg::CTL_ULO])  gbus[8:0]   = gbus[8:0]   | instr[8:0];
    if (ctrl[cbss_pkg::CTL_UMID]) gbus[10:9]  = gbus[10:9]  | instr[10:9];
    if (ctrl[cbss_pkg::CTL_UHI])  gbus[15:11] = gbus[15:11] | instr[15:11];
  end

  // adder: s bus plus g bus when selected, plus one for pc update
  always_comb begin
    sum = sbus
        + (ctrl[cbss_pkg::CTL_GADD] ? gbus : '0)
        + {{(W-1){1'b0}}, ctrl[cbss_pkg::CTL_PCINC] && ctrl[cbss_pkg::CTL_PC_S]};
    next_cbus = ctrl[cbss_pkg::CTL_ADDC] ? sum : gbus;
  end

  assign shifting = (op != cbss_pkg::OP_NONE);
  assign target   = ctrl[cbss_pkg::CTL_LONG] ? acc : ext;

  cbss_shift_gates #(.W(W)) u_gates (
    .op          (op),
    .active      (shifting),
    .word        (target),
    .gate_first  (g_first),
    .gate_second (g_second),
    .gate_third  (g_third),
    .gate_fourth (g_fourth),
    .left_en     (l_en),
    .right_en    (r_en),
    .shifted     (shifted)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cbus                   <= cbss_pkg::RST_WORD;
      left_shift_enable      <= 1'b0;
      right_shift_enable     <= 1'b0;
      shift_operation_enable <= 1'b0;
    end else begin
      cbus                   <= next_cbus;
      left_shift_enable      <= l_en;
      right_shift_enable     <= r_en;
      shift_operation_enable <= shifting;
    end
  end

  // working registers load from the c bus on their strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc       <= cbss_pkg::RST_WORD;
      ext       <= cbss_pkg::RST_WORD;
      pc        <= cbss_pkg::RST_WORD;
      index_reg <= cbss_pkg::RST_WORD;
      mdr       <= cbss_pkg::RST_WORD;
      instr     <= cbss_pkg::RST_WORD;
      opnd      <= cbss_pkg::RST_WORD;
    end else begin
      if (strobe[cbss_pkg::STB_MDR]) mdr <= cbus;
      if (strobe[cbss_pkg::STB_IDX]) index_reg <= cbus;
      if (strobe[cbss_pkg::STB_ACC]) acc <= cbus;
      // muldiv load is a separate path into the extension register
      if (strobe[cbss_pkg::STB_EXT] || strobe[cbss_pkg::STB_MDEXT]) ext <= cbus;
      if (strobe[cbss_pkg::STB_PC]) pc <= cbus;
      // instruction changes only on its own strobe, held through execute
      if (strobe[cbss_pkg::STB_INSTR]) instr <= cbus;
      if (strobe[cbss_pkg::STB_OPND]) opnd <= cbus;
      if (strobe[cbss_pkg::STB_STEP] && shifting) begin
        if (ctrl[cbss_pkg::CTL_LONG]) acc <= shifted;
        else ext <= shifted;
      end
    end
  end

  // read word picked from the address phase; registered so hrdata stands in the data phase
  // limitation: a read right behind a write to the same register returns the old value
  always_comb begin
    rd_word = cbss_pkg::RD_ZERO;
    case (haddr[7:0])
      cbss_pkg::ADDR_CTRL:   rd_word[cbss_pkg::CTL_W-1:0] = ctrl;
      cbss_pkg::ADDR_OP:     rd_word[cbss_pkg::OP_W-1:0] = op;
      cbss_pkg::ADDR_ACC:    rd_word[W-1:0] = acc;
      cbss_pkg::ADDR_EXT:    rd_word[W-1:0] = ext;
      cbss_pkg::ADDR_PC:     rd_word[W-1:0] = pc;
      cbss_pkg::ADDR_INDEX:  rd_word[W-1:0] = index_reg;
      cbss_pkg::ADDR_MDR:    rd_word[W-1:0] = mdr;
      cbss_pkg::ADDR_INSTR:  rd_word[W-1:0] = instr;
      cbss_pkg::ADDR_OPND:   rd_word[W-1:0] = opnd;
      cbss_pkg::ADDR_BUSES:  rd_word = {sbus, gbus};
      cbss_pkg::ADDR_STATUS: rd_word[6:0] = {g_fourth, g_third, g_second, g_first,
                                             shift_operation_enable,
                                             right_shift_enable, left_shift_enable};
      default: rd_word = cbss_pkg::RD_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= cbss_pkg::RD_ZERO;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  property p_mdr_load;
    @(posedge hclk) disable iff (!hresetn)
      strobe[cbss_pkg::STB_MDR] |=> (mdr == $past(cbus));
  endproperty
  a_mdr_load: assert property (p_mdr_load) else $error("mdr missed c bus");

  property p_idx_load;
    @(posedge hclk) disable iff (!hresetn)
      strobe[cbss_pkg::STB_IDX] |=> (index_reg == $past(cbus));
  endproperty
  a_idx_load: assert property (p_idx_load) else $error("index missed c bus");

  property p_left;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_SHL || op == cbss_pkg::OP_DIV) |=> left_shift_enable;
  endproperty
  a_left: assert property (p_left) else $error("left enable missing");

  property p_right;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_SHR || op == cbss_pkg::OP_MUL) |=> right_shift_enable;
  endproperty
  a_right: assert property (p_right) else $error("right enable missing");

  property p_excl;
    @(posedge hclk) disable iff (!hresetn)
      !(left_shift_enable && right_shift_enable);
  endproperty
  a_excl: assert property (p_excl) else $error("both shift enables");

  property p_shift_only;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_NONE) |=> !shift_operation_enable && !left_shift_enable;
  endproperty
  a_shift_only: assert property (p_shift_only) else $error("shift without op");

  property p_adder_cbus;
    @(posedge hclk) disable iff (!hresetn)
      ctrl[cbss_pkg::CTL_ADDC] |=> (cbus == $past(sum));
  endproperty
  a_adder_cbus: assert property (p_adder_cbus) else $error("c bus not sum");

  property p_instr_hold;
    @(posedge hclk) disable iff (!hresetn)
      !strobe[cbss_pkg::STB_INSTR] |=> $stable(instr);
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("instr changed");

  property p_pc_inc;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl == (cbss_pkg::CTL_W'(1) << cbss_pkg::CTL_PC_S | cbss_pkg::CTL_W'(1)
                << cbss_pkg::CTL_PCINC | cbss_pkg::CTL_W'(1) << cbss_pkg::CTL_ADDC))
        |=> (cbus == W'($past(pc) + 1));
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc not incremented");

  property p_gate_shl;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_SHL) |-> (g_first && g_fourth && !g_second && !g_third);
  endproperty
  a_gate_shl: assert property (p_gate_shl) else $error("shl gates wrong");

  property p_gate_mul;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_MUL) |-> (g_first && g_second && g_third && !g_fourth);
  endproperty
  a_gate_mul: assert property (p_gate_mul) else $error("mul gates wrong");

  property p_gate_shr;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_SHR) |-> (g_second && g_third && !g_first && !g_fourth);
  endproperty
  a_gate_shr: assert property (p_gate_shr) else $error("shr gates wrong");

  property p_gate_div;
    @(posedge hclk) disable iff (!hresetn)
      (op == cbss_pkg::OP_DIV) |-> (g_fourth && !g_first && !g_second && !g_third);
  endproperty
  a_gate_div: assert property (p_gate_div) else $error("div gates wrong");

  property p_step_left;
    @(posedge hclk) disable iff (!hresetn)
      (strobe[cbss_pkg::STB_STEP] && op == cbss_pkg::OP_SHL && ctrl[cbss_pkg::CTL_LONG])
        |=> (acc == {$past(acc[W-2:0]), $past(acc[W-1])});
  endproperty
  a_step_left: assert property (p_step_left) else $error("left step wrong");

  property p_step_right;
    @(posedge hclk) disable iff (!hresetn)
      (strobe[cbss_pkg::STB_STEP] && ctrl[cbss_pkg::CTL_LONG]
       && (op == cbss_pkg::OP_SHR || op == cbss_pkg::OP_MUL))
        |=> (acc == {$past(acc[W-1]), $past(acc[W-1:1])});
  endproperty
  a_step_right: assert property (p_step_right) else $error("right step wrong");

  property p_step_ext;
    @(posedge hclk) disable iff (!hresetn)
      (strobe[cbss_pkg::STB_STEP] && !ctrl[cbss_pkg::CTL_LONG] && !strobe[cbss_pkg::STB_ACC])
        |=> $stable(acc);
  endproperty
  a_step_ext: assert property (p_step_ext) else $error("short shift moved acc");

  property p_muldiv_ext;
    @(posedge hclk) disable iff (!hresetn)
      (strobe[cbss_pkg::STB_MDEXT] && !strobe[cbss_pkg::STB_STEP]) |=> (ext == $past(cbus));
  endproperty
  a_muldiv_ext: assert property (p_muldiv_ext) else $error("muldiv load missed");

  property p_sbus_acc;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_ACC_S] && !ctrl[cbss_pkg::CTL_EXT_S] && !ctrl[cbss_pkg::CTL_PC_S]
       && !ctrl[cbss_pkg::CTL_IDX_S]) |-> (sbus == acc);
  endproperty
  a_sbus_acc: assert property (p_sbus_acc) else $error("s bus not acc");

  property p_sbus_ext;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_EXT_S] && !ctrl[cbss_pkg::CTL_ACC_S] && !ctrl[cbss_pkg::CTL_PC_S]
       && !ctrl[cbss_pkg::CTL_IDX_S]) |-> (sbus == ext);
  endproperty
  a_sbus_ext: assert property (p_sbus_ext) else $error("s bus not ext");

  property p_gbus_inv;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_OPNDI] && !ctrl[cbss_pkg::CTL_OPND] && !ctrl[cbss_pkg::CTL_ULO]
       && !ctrl[cbss_pkg::CTL_UMID] && !ctrl[cbss_pkg::CTL_UHI]) |-> (gbus == ~opnd);
  endproperty
  a_gbus_inv: assert property (p_gbus_inv) else $error("g bus not inverted operand");

  property p_gbus_ulo;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_ULO] && !ctrl[cbss_pkg::CTL_OPND] && !ctrl[cbss_pkg::CTL_OPNDI])
        |-> (gbus[8:0] == instr[8:0]);
  endproperty
  a_gbus_ulo: assert property (p_gbus_ulo) else $error("low group missing");

  property p_gbus_umid;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_UMID] && !ctrl[cbss_pkg::CTL_OPND] && !ctrl[cbss_pkg::CTL_OPNDI])
        |-> (gbus[10:9] == instr[10:9]);
  endproperty
  a_gbus_umid: assert property (p_gbus_umid) else $error("mid group missing");

  property p_gbus_uhi;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_UHI] && !ctrl[cbss_pkg::CTL_OPND] && !ctrl[cbss_pkg::CTL_OPNDI])
        |-> (gbus[15:11] == instr[15:11]);
  endproperty
  a_gbus_uhi: assert property (p_gbus_uhi) else $error("high group missing");

  property p_gadd;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl[cbss_pkg::CTL_GADD] && !ctrl[cbss_pkg::CTL_PCINC]) |-> (sum == W'(sbus + gbus));
  endproperty
  a_gadd: assert property (p_gadd) else $error("g bus not added");

  property p_cbus_gbus;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl[cbss_pkg::CTL_ADDC] |=> (cbus == $past(gbus));
  endproperty
  a_cbus_gbus: assert property (p_cbus_gbus) else $error("c bus not g bus");

  c_mul: cover property (@(posedge hclk) op == cbss_pkg::OP_MUL ##1 right_shift_enable);
  c_div: cover property (@(posedge hclk) op == cbss_pkg::OP_DIV ##1 left_shift_enable);
  c_mdext: cover property (@(posedge hclk) strobe[cbss_pkg::STB_MDEXT]);
  c_long_shr: cover property (@(posedge hclk) strobe[cbss_pkg::STB_STEP]
                              && ctrl[cbss_pkg::CTL_LONG] && op == cbss_pkg::OP_SHR);
endmodule

// ===== test/cbss_seq_model.sv
// sequencer model: issues select and strobe words over ahb-lite, single word transfers
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
module cbss_seq_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  logic [31:0] rd_q;
  logic        rdy_q;

  // values seen at the edge itself, before that edge's updates land
  always @(posedge hclk) begin
    rd_q  <= hrdata;
    rdy_q <= hready;
  end

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do begin
      @(posedge hclk);
      #1;
    end while (rdy_q !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      #1;
    end while (rdy_q !== 1'b1);
    r = rd_q;
  endtask

  // the option's own b-load pulse, apart from the normal b strobe
  task automatic muldiv_load();
    logic [31:0] r;
    xfer(1'b1, {24'h00_0000, cbss_pkg::ADDR_STROBE}, 32'h0000_0001 << cbss_pkg::STB_MDEXT, r);
  endtask
endmodule

// ===== test/tb_cpu_bus_shift_select.sv
// self-checking bench for the bus-select and shift-gating datapath
// assumes the sequencer model as sole bus master; registers start at zero
`timescale 1ns/10ps
module tb_cpu_bus_shift_select;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        left_shift_enable;
  logic        right_shift_enable;
  logic        shift_operation_enable;
  logic [15:0] cbus;
  logic [31:0] rdat;
  logic [2:0]  op_tab  [5];
  logic [15:0] acc_tab [5];
  logic [2:0]  flg_tab [5];
  logic [6:0]  sts_tab [5];
  int          n_mismatch;
  int          compares;

  cbss_seq_model u_seq (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
                        .hsize, .hwdata);
  cbss_datapath u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                       .hready(hreadyout), .hrdata, .hreadyout, .hresp, .left_shift_enable,
                       .right_shift_enable, .shift_operation_enable, .cbus);

  always #5 hclk = ~hclk;

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_seq.xfer(1'b1, {24'h00_0000, a}, {16'h0000, d}, rdat);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_seq.xfer(1'b0, {24'h00_0000, a}, 32'h0000_0000, rdat);
    chk(rdat, {16'h0000, e});
  endtask

  // c bus follows a select word one edge after it is written
  task automatic ctl(input logic [15:0] c, input logic [15:0] e);
    wr(cbss_pkg::ADDR_CTRL, c);
    @(posedge hclk);
    #1;
    chk({16'h0000, cbus}, {16'h0000, e});
  endtask

  task automatic flags(input logic [2:0] e);
    chk({29'h0000_0000, shift_operation_enable, right_shift_enable, left_shift_enable},
        {29'h0000_0000, e});
  endtask

  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    op_tab = '{cbss_pkg::OP_SHL, cbss_pkg::OP_DIV, cbss_pkg::OP_SHR, cbss_pkg::OP_MUL,
               cbss_pkg::OP_NONE};
    acc_tab = '{16'hFFFD, 16'hFFFB, 16'hFFFD, 16'hFFFE, 16'hFFFE};
    flg_tab = '{3'b101, 3'b101, 3'b110, 3'b110, 3'b000};
    // {gate4, gate3, gate2, gate1, shift, right, left} per operation
    sts_tab = '{7'h4D, 7'h45, 7'h36, 7'h3E, 7'h00};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    flags(3'b000);
    rd(cbss_pkg::ADDR_ACC, 16'h0000);
    ctl(16'h0020, 16'hFFFF);
    wr(cbss_pkg::ADDR_STROBE, 16'h0004);
    ctl(16'h0621, 16'hFFFE);
    wr(cbss_pkg::ADDR_STROBE, 16'h0005);
    rd(cbss_pkg::ADDR_MDR, 16'hFFFE);
    rd(cbss_pkg::ADDR_ACC, 16'hFFFE);
    ctl(16'h0401, 16'hFFFE);
    wr(cbss_pkg::ADDR_STROBE, 16'h0040);
    ctl(16'h0010, 16'hFFFE);
    wr(cbss_pkg::ADDR_STROBE, 16'h0022);
    rd(cbss_pkg::ADDR_INDEX, 16'hFFFE);
    ctl(16'h0040, 16'h01FE);
    ctl(16'h0080, 16'h0600);
    ctl(16'h0100, 16'hF800);
    ctl(16'h0020, 16'h0001);
    u_seq.muldiv_load();
    rd(cbss_pkg::ADDR_EXT, 16'h0001);
    ctl(16'h0C04, 16'h0001);
    wr(cbss_pkg::ADDR_STROBE, 16'h0010);
    wr(cbss_pkg::ADDR_STROBE, 16'h0010);
    rd(cbss_pkg::ADDR_PC, 16'h0002);
    ctl(16'h0C01, 16'hFFFE);
    ctl(16'h0402, 16'h0001);
    u_seq.xfer(1'b0, {24'h00_0000, cbss_pkg::ADDR_BUSES}, 32'h0000_0000, rdat);
    chk(rdat, 32'h0001_0000);
    ctl(16'h0404, 16'h0002);
    ctl(16'h0408, 16'hFFFE);
    ctl(16'h1000, 16'h0000);
    // a register is the shift target while the long-shift select is set
    for (int i = 0; i < 5; i++) begin
      wr(cbss_pkg::ADDR_OP, {13'h0000, op_tab[i]});
      @(posedge hclk);
      #1;
      flags(flg_tab[i]);
      wr(cbss_pkg::ADDR_STROBE, 16'h0100);
      rd(cbss_pkg::ADDR_ACC, acc_tab[i]);
      u_seq.xfer(1'b0, {24'h00_0000, cbss_pkg::ADDR_STATUS}, 32'h0000_0000, rdat);
      chk(rdat, {25'h000_0000, sts_tab[i]});
    end
    ctl(16'h0000, 16'h0000);
    wr(cbss_pkg::ADDR_OP, {13'h0000, cbss_pkg::OP_SHL});
    wr(cbss_pkg::ADDR_STROBE, 16'h0100);
    rd(cbss_pkg::ADDR_EXT, 16'h0002);
    rd(cbss_pkg::ADDR_ACC, 16'hFFFE);
    u_seq.xfer(1'b0, {24'h00_0000, cbss_pkg::ADDR_STATUS}, 32'h0000_0000, rdat);
    chk(rdat, 32'h0000_004D);
    rd(cbss_pkg::ADDR_INSTR, 16'hFFFE);
    wr(8'h30, 16'h1234);
    rd(8'h30, 16'h0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    close_out();
  end
endmodule
